/* File: include/fpcpe_pkg.sv */
// constants and types of the floating-point condition predicate evaluator
// assumes a 32-bit Avalon-MM register bus with byte addresses
package fpcpe_pkg;
    // ========================================
    // register byte offsets
    localparam logic [3:0] FPCPE_OFS_CTRL = 4'h0;
    localparam logic [3:0] FPCPE_OFS_STATUS = 4'h4;
    localparam logic [3:0] FPCPE_OFS_INT_STATUS = 4'h8;
    localparam logic [3:0] FPCPE_OFS_INT_MASK = 4'hC;
    localparam logic [3:0] FPCPE_OFS_LAST_EVAL = 4'h0;
    localparam logic [1:0] FPCPE_PAGE_REGS = 2'h0;
    localparam logic [1:0] FPCPE_PAGE_EVAL = 2'h1;
    // ========================================
    // condition code bits inside the cc vector
    localparam int FPCPE_CC_NAN = 0;
    localparam int FPCPE_CC_INF = 1;
    localparam int FPCPE_CC_ZERO = 2;
    localparam int FPCPE_CC_NEG = 3;
    localparam int FPCPE_CC_W = 4;
    // ========================================
    // field positions in the registers
    localparam int FPCPE_STAT_CC_LSB = 24;
    localparam int FPCPE_STAT_EXC_LSB = 8;
    localparam int FPCPE_EXC_BU_BIT = 7;
    localparam int FPCPE_CTRL_BU_TRAP = 15;
    localparam int FPCPE_INT_BU = 0;
    localparam int FPCPE_INT_NAN = 1;
    localparam int FPCPE_INT_BADPRED = 2;
    localparam int FPCPE_INT_W = 3;
    localparam int FPCPE_LAST_OUT_BIT = 8;
    localparam int FPCPE_LAST_VALID_BIT = 9;
    // ========================================
    // reset values and predicate coding
    localparam logic [FPCPE_CC_W-1:0] FPCPE_CC_RESET = 4'h0;
    localparam logic [7:0] FPCPE_EXC_RESET = 8'h00;
    localparam logic [FPCPE_INT_W-1:0] FPCPE_INT_RESET = 3'h0;
    localparam int FPCPE_PRED_W = 6;
    localparam int FPCPE_PRED_SIG_BIT = 4;
    localparam int FPCPE_PRED_BAD_BIT = 5;
    localparam logic [31:0] FPCPE_READ_ZERO = 32'h00000000;

    typedef enum logic [0:0] {
        FPCPE_BUS_IDLE = 1'b0,
        FPCPE_BUS_ACK = 1'b1
    } fpcpe_bus_state_t;
endpackage

/* File: include/fpcpe_cc_if.sv */
// condition code bits shared between the holder and the evaluator
// assumes one clock domain
`timescale 1ns/10ps
`default_nettype none
interface fpcpe_cc_if;
    logic [fpcpe_pkg::FPCPE_CC_W-1:0] cc;
    modport source (output cc);
    modport sink (input cc);
endinterface
`default_nettype wire

/* File: verilog/fpcpe_pred_eval.sv */
// combinational decode of a 6-bit predicate against the condition bits
// assumes the cc vector comes from the condition code holder
`timescale 1ns/10ps
`default_nettype none
module fpcpe_pred_eval
    import fpcpe_pkg::*;
(
    input wire logic [fpcpe_pkg::FPCPE_PRED_W-1:0] pred,
    fpcpe_cc_if.sink cc_in,
    output logic test_true,
    output logic raise_bu,
    output logic bad_pred
);
    // ========================================
    // test equations on the low four predicate bits
    function automatic logic pred_test(input logic [3:0] p, input logic n, input logic z,
                                       input logic nan);
        logic r;
        r = 1'b0;
        unique case (p)
            4'h0: r = 1'b0;
            4'h1: r = z;
            4'h2: r = ~(nan | z | n);
            4'h3: r = z | ~(nan | n);
            4'h4: r = n & ~(nan | z);
            4'h5: r = z | (n & ~nan);
            4'h6: r = ~(nan | z);
            4'h7: r = ~nan;
            4'h8: r = nan;
            4'h9: r = nan | z;
            4'hA: r = nan | ~(n | z);
            4'hB: r = nan | z | ~n;
            4'hC: r = nan | (n & ~z);
            4'hD: r = nan | z | n;
            4'hE: r = ~z;
            4'hF: r = 1'b1;
        endcase
        return r;
    endfunction

    logic nan_b;
    assign nan_b = cc_in.cc[FPCPE_CC_NAN];
    assign bad_pred = pred[FPCPE_PRED_BAD_BIT];
    // ========================================
    // outcome and branch-unordered decision
    assign test_true = ~bad_pred & pred_test(pred[3:0], cc_in.cc[FPCPE_CC_NEG],
                                             cc_in.cc[FPCPE_CC_ZERO], nan_b);
    assign raise_bu = ~bad_pred & pred[FPCPE_PRED_SIG_BIT] & nan_b;
endmodule
`default_nettype wire

/* File: verilog/fpcpe_cc_hold.sv */
// holds the negative, zero, infinity and not-a-number condition bits
// assumes result reports come from arithmetic logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module fpcpe_cc_hold
    import fpcpe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic upd_valid,
    input wire logic upd_neg,
    input wire logic upd_zero,
    input wire logic upd_inf,
    input wire logic upd_nan,
    input wire logic upd_unordered,
    input wire logic sw_wr,
    input wire logic [fpcpe_pkg::FPCPE_CC_W-1:0] sw_cc,
    output logic nan_event,
    fpcpe_cc_if.source cc_out
);
    // ========================================
    // next condition bits from a result
    logic [FPCPE_CC_W-1:0] cc_q;
    logic [FPCPE_CC_W-1:0] res_cc;
    always_comb begin
        res_cc = FPCPE_CC_RESET;
        res_cc[FPCPE_CC_NEG] = upd_neg;
        res_cc[FPCPE_CC_ZERO] = upd_zero & ~upd_nan;
        res_cc[FPCPE_CC_INF] = upd_inf & ~upd_nan;
        res_cc[FPCPE_CC_NAN] = upd_nan | upd_unordered;
    end
    // ========================================
    // register: a result report wins over a software write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cc_q <= FPCPE_CC_RESET;
        end else if (upd_valid) begin
            cc_q <= res_cc;
        end else if (sw_wr) begin
            cc_q <= sw_cc;
        end
    end
    assign nan_event = upd_valid & res_cc[FPCPE_CC_NAN];
    assign cc_out.cc = cc_q;
endmodule
`default_nettype wire

/* File: verilog/fpcpe_top.sv */
// floating-point condition predicate evaluator with Avalon-MM registers
// assumes result reports and evaluation requests from logic on clock
//
// Design decisions made here: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module fpcpe_top
    import fpcpe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic res_valid,
    input wire logic res_neg,
    input wire logic res_zero,
    input wire logic res_inf,
    input wire logic res_nan,
    input wire logic res_unordered,
    input wire logic eval_valid,
    input wire logic [fpcpe_pkg::FPCPE_PRED_W-1:0] eval_pred,
    output logic eval_done,
    output logic eval_true,
    output logic eval_trap,
    output logic irq
);
    import fpcpe_pkg::*;

    // ========================================
    // address decode helpers
    function automatic logic hit(input logic [5:0] a, input logic [1:0] page,
                                 input logic [3:0] ofs);
        return (a[5:4] == page) && (a[3:0] == ofs);
    endfunction

    function automatic logic [31:0] be_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    // ========================================
    // bus slave state
    fpcpe_bus_state_t bus_q;
    fpcpe_bus_state_t bus_d;
    logic req;
    logic take;
    logic wr_take;
    logic rd_take;
    logic [31:0] wmask;
    logic [31:0] wbits;

    assign req = avs_read | avs_write;
    always_comb begin
        bus_d = bus_q;
        unique case (bus_q)
            FPCPE_BUS_IDLE: begin
                if (req) begin
                    bus_d = FPCPE_BUS_ACK;
                end
            end
            FPCPE_BUS_ACK: begin
                bus_d = FPCPE_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bus_q <= FPCPE_BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    assign take = req && (bus_q == FPCPE_BUS_ACK);
    assign wr_take = take & avs_write;
    assign rd_take = take & avs_read;
    assign avs_waitrequest = req && (bus_q == FPCPE_BUS_IDLE);
    assign wmask = be_mask(avs_byteenable);
    assign wbits = avs_writedata & wmask;

    logic wr_ctrl;
    logic wr_status;
    logic wr_int_status;
    logic wr_int_mask;
    assign wr_ctrl = wr_take & hit(avs_address, FPCPE_PAGE_REGS, FPCPE_OFS_CTRL);
    assign wr_status = wr_take & hit(avs_address, FPCPE_PAGE_REGS, FPCPE_OFS_STATUS);
    assign wr_int_status = wr_take & hit(avs_address, FPCPE_PAGE_REGS, FPCPE_OFS_INT_STATUS);
    assign wr_int_mask = wr_take & hit(avs_address, FPCPE_PAGE_REGS, FPCPE_OFS_INT_MASK);

    // ========================================
    // control register: branch-unordered trap enable
    logic bu_trap_en_q;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bu_trap_en_q <= 1'b0;
        end else if (wr_ctrl && wmask[FPCPE_CTRL_BU_TRAP]) begin
            bu_trap_en_q <= avs_writedata[FPCPE_CTRL_BU_TRAP];
        end
    end

    // ========================================
    // condition code holder and predicate evaluator
    fpcpe_cc_if cc_bus ();
    logic nan_event;
    logic cc_sw_wr;
    logic [FPCPE_CC_W-1:0] cc_sw_val;
    logic [FPCPE_CC_W-1:0] cc_now;
    logic [3:0] cc_lane;

    assign cc_lane = {avs_byteenable[3], avs_byteenable[3], avs_byteenable[3],
                      avs_byteenable[3]};
    assign cc_sw_wr = wr_status & avs_byteenable[3];
    assign cc_sw_val = avs_writedata[FPCPE_STAT_CC_LSB +: FPCPE_CC_W] & cc_lane;

    fpcpe_cc_hold u_cc (
        .clock(clock),
        .rst_b(rst_b),
        .upd_valid(res_valid),
        .upd_neg(res_neg),
        .upd_zero(res_zero),
        .upd_inf(res_inf),
        .upd_nan(res_nan),
        .upd_unordered(res_unordered),
        .sw_wr(cc_sw_wr),
        .sw_cc(cc_sw_val),
        .nan_event(nan_event),
        .cc_out(cc_bus.source)
    );

    assign cc_now = cc_bus.cc;

    logic test_true;
    logic raise_bu;
    logic bad_pred;

    fpcpe_pred_eval u_pred (
        .pred(eval_pred),
        .cc_in(cc_bus.sink),
        .test_true(test_true),
        .raise_bu(raise_bu),
        .bad_pred(bad_pred)
    );

    // ========================================
    // evaluation answer, one cycle after the request
    logic bu_event;
    assign bu_event = eval_valid & raise_bu;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            eval_done <= 1'b0;
            eval_true <= 1'b0;
        end else begin
            eval_done <= eval_valid;
            eval_true <= eval_valid & test_true;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            eval_trap <= 1'b0;
        end else begin
            eval_trap <= bu_event & bu_trap_en_q;
        end
    end

    // ========================================
    // exception byte: branch-unordered flag, write one to clear
    logic bu_flag_q;
    logic bu_clr;
    assign bu_clr = wr_status && wbits[FPCPE_STAT_EXC_LSB + FPCPE_EXC_BU_BIT];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            bu_flag_q <= FPCPE_EXC_RESET[FPCPE_EXC_BU_BIT];
        end else if (bu_event) begin
            bu_flag_q <= 1'b1;
        end else if (bu_clr) begin
            bu_flag_q <= 1'b0;
        end
    end

    logic [7:0] exc_byte;
    always_comb begin
        exc_byte = FPCPE_EXC_RESET;
        exc_byte[FPCPE_EXC_BU_BIT] = bu_flag_q;
    end

    // ========================================
    // last evaluation record
    logic [FPCPE_PRED_W-1:0] last_pred_q;
    logic last_out_q;
    logic last_valid_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            last_pred_q <= {FPCPE_PRED_W{1'b0}};
            last_out_q <= 1'b0;
            last_valid_q <= 1'b0;
        end else if (eval_valid) begin
            last_pred_q <= eval_pred;
            last_out_q <= test_true;
            last_valid_q <= 1'b1;
        end
    end

    // ========================================
    // interrupt status and mask
    logic [FPCPE_INT_W-1:0] int_status_q;
    logic [FPCPE_INT_W-1:0] int_mask_q;
    logic [FPCPE_INT_W-1:0] int_set;
    logic [FPCPE_INT_W-1:0] int_clr;

    always_comb begin
        int_set = FPCPE_INT_RESET;
        int_set[FPCPE_INT_BU] = bu_event;
        int_set[FPCPE_INT_NAN] = nan_event;
        int_set[FPCPE_INT_BADPRED] = eval_valid & bad_pred;
        int_clr = FPCPE_INT_RESET;
        if (wr_int_status) begin
            int_clr = wbits[FPCPE_INT_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            int_status_q <= FPCPE_INT_RESET;
        end else begin
            int_status_q <= (int_status_q & ~int_clr) | int_set;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            int_mask_q <= FPCPE_INT_RESET;
        end else if (wr_int_mask) begin
            int_mask_q <= (int_mask_q & ~wmask[FPCPE_INT_W-1:0]) | wbits[FPCPE_INT_W-1:0];
        end
    end

    assign irq = |(int_status_q & int_mask_q);

    // ========================================
    // read data mux
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = FPCPE_READ_ZERO;
        if (hit(avs_address, FPCPE_PAGE_REGS, FPCPE_OFS_CTRL)) begin
            rd_mux[FPCPE_CTRL_BU_TRAP] = bu_trap_en_q;
        end else if (hit(avs_address, FPCPE_PAGE_REGS, FPCPE_OFS_STATUS)) begin
            rd_mux[FPCPE_STAT_CC_LSB +: FPCPE_CC_W] = cc_now;
            rd_mux[FPCPE_STAT_EXC_LSB +: 8] = exc_byte;
        end else if (hit(avs_address, FPCPE_PAGE_REGS, FPCPE_OFS_INT_STATUS)) begin
            rd_mux[FPCPE_INT_W-1:0] = int_status_q;
        end else if (hit(avs_address, FPCPE_PAGE_REGS, FPCPE_OFS_INT_MASK)) begin
            rd_mux[FPCPE_INT_W-1:0] = int_mask_q;
        end else if (hit(avs_address, FPCPE_PAGE_EVAL, FPCPE_OFS_LAST_EVAL)) begin
            rd_mux[FPCPE_PRED_W-1:0] = last_pred_q;
            rd_mux[FPCPE_LAST_OUT_BIT] = last_out_q;
            rd_mux[FPCPE_LAST_VALID_BIT] = last_valid_q;
        end
    end

    // ========================================
    // read data register, loaded in the wait cycle so it stands at the taking edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            avs_readdata <= FPCPE_READ_ZERO;
        end else if (avs_read && (bus_q == FPCPE_BUS_IDLE)) begin
            avs_readdata <= rd_mux;
        end
    end

    logic unused_rd;
    assign unused_rd = rd_take;
endmodule
`default_nettype wire

/* File: verif/fpcpe_properties.sv */
// concurrent checks on the ports of the predicate evaluator top
// assumes one clock domain and an asynchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module fpcpe_properties
    import fpcpe_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic res_valid,
    input wire logic res_neg,
    input wire logic res_zero,
    input wire logic res_inf,
    input wire logic res_nan,
    input wire logic res_unordered,
    input wire logic eval_valid,
    input wire logic [fpcpe_pkg::FPCPE_PRED_W-1:0] eval_pred,
    input wire logic eval_done,
    input wire logic eval_true,
    input wire logic eval_trap,
    input wire logic irq
);
    // ========================================
    // evaluation and bus timing
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_done_next: assert property (eval_valid |=> eval_done)
        else $error("no completion after request");
    a_done_cause: assert property (eval_done |-> $past(eval_valid))
        else $error("completion without request");
    a_true_qual: assert property (eval_true |-> eval_done)
        else $error("outcome outside completion");
    a_trap_qual: assert property (eval_trap |-> eval_done)
        else $error("trap outside completion");
    a_aware_quiet: assert property (eval_valid && !eval_pred[4] |=> !eval_trap)
        else $error("aware test raised trap");
    a_false_const: assert property (eval_valid && eval_pred[3:0] == 4'h0 |=> !eval_true)
        else $error("false test returned true");
    a_true_const: assert property (eval_valid && !eval_pred[5] && eval_pred[3:0] == 4'hF
        |=> eval_true)
        else $error("true test returned false");
    a_bad_pred: assert property (eval_valid && eval_pred[5] |=> !eval_true && !eval_trap)
        else $error("illegal predicate not quiet");
    a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
        else $error("no wait state on new access");
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait state too long");
endmodule
`default_nettype wire

/* File: verif/fpcpe_host_model.sv */
// host side issuing result reports and conditional evaluations
// assumes tasks are called from the bench on one clock
`timescale 1ns/10ps
`default_nettype none
module fpcpe_host_model (
    input wire logic clock,
    output logic res_valid,
    output logic res_neg,
    output logic res_zero,
    output logic res_inf,
    output logic res_nan,
    output logic res_unordered,
    output logic eval_valid,
    output logic [5:0] eval_pred,
    input wire logic eval_done,
    input wire logic eval_true,
    input wire logic eval_trap
);
    // ========================================
    // idle lines carry inverted junk, never the last value
    initial begin
        res_valid = 1'b0;
        {res_neg, res_zero, res_inf, res_nan, res_unordered} = 5'h15;
        eval_valid = 1'b0;
        eval_pred = 6'h2A;
    end
    task automatic report(input logic n, input logic z, input logic i, input logic nn,
        input logic un);
        @(posedge clock);
        res_valid <= 1'b1;
        {res_neg, res_zero, res_inf, res_nan, res_unordered} <= {n, z, i, nn, un};
        @(posedge clock);
        res_valid <= 1'b0;
        {res_neg, res_zero, res_inf, res_nan, res_unordered} <= ~{n, z, i, nn, un};
    endtask
    task automatic evaluate(input logic [5:0] p, output logic d, output logic t,
        output logic tr);
        @(posedge clock);
        eval_valid <= 1'b1;
        eval_pred <= p;
        @(posedge clock);
        eval_valid <= 1'b0;
        eval_pred <= ~p;
        @(negedge clock);
        d = eval_done;
        t = eval_true;
        tr = eval_trap;
    endtask
endmodule
`default_nettype wire

/* File: verif/fpcpe_tb_top.sv */
// self-checking bench for the predicate evaluator
// assumes the host model drives the result and evaluation ports
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin failures++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module fpcpe_tb_top;
    import fpcpe_pkg::*;
    logic clock, rst_b, avs_read, avs_write, avs_waitrequest, irq;
    logic [5:0] avs_address, eval_pred;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic res_valid, res_neg, res_zero, res_inf, res_nan, res_unordered;
    logic eval_valid, eval_done, eval_true, eval_trap, dn, tv, tp;
    int failures, check_count;
    always #4 clock = ~clock;
    fpcpe_top dut (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .res_valid(res_valid), .res_neg(res_neg),
        .res_zero(res_zero), .res_inf(res_inf), .res_nan(res_nan),
        .res_unordered(res_unordered), .eval_valid(eval_valid), .eval_pred(eval_pred),
        .eval_done(eval_done), .eval_true(eval_true), .eval_trap(eval_trap), .irq(irq));
    fpcpe_host_model host (.clock(clock), .res_valid(res_valid), .res_neg(res_neg),
        .res_zero(res_zero), .res_inf(res_inf), .res_nan(res_nan),
        .res_unordered(res_unordered), .eval_valid(eval_valid), .eval_pred(eval_pred),
        .eval_done(eval_done), .eval_true(eval_true), .eval_trap(eval_trap));
    // ========================================
    // bus access and expectations
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= ~wr;
        avs_write <= wr;
        @(posedge clock);
        while (avs_waitrequest) @(posedge clock);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    function automatic logic exp_true(input logic [5:0] p, input logic nan, input logic z,
        input logic n);
        logic [7:0] b;
        logic [3:0] k;
        b = {~nan, ~nan & ~z, z | (n & ~nan), n & ~nan & ~z, z | (~nan & ~n),
            ~(nan | z | n), z, 1'b0};
        k = p[3] ? 4'hF - p[3:0] : p[3:0];
        if (p[5]) return 1'b0;
        return p[3] ? ~b[k[2:0]] : b[k[2:0]];
    endfunction
    // ========================================
    // scenarios
    task automatic t_regs;
        bus(1'b0, 6'h04, 32'h0, 4'h0);
        `CHK("status reset", 32'h00000000, rd)
        bus(1'b1, 6'h20, 32'hFFFFFFFF, 4'hF);
        bus(1'b0, 6'h20, 32'h0, 4'h0);
        `CHK("unmapped", 32'h00000000, rd)
        $display("test regs done");
    endtask
    task automatic t_cc;
        logic [4:0] v[7] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01, 5'h0A, 5'h18};
        logic [3:0] e[7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h1, 4'h1, 4'hC};
        bus(1'b1, 6'h04, 32'h0A000000, 4'h8);
        bus(1'b0, 6'h04, 32'h0, 4'h0);
        `CHK("cc write", 4'hA, rd[27:24])
        for (int i = 0; i < 7; i++) begin
            host.report(v[i][4], v[i][3], v[i][2], v[i][1], v[i][0]);
            bus(1'b0, 6'h04, 32'h0, 4'h0);
            `CHK("cc bits", e[i], rd[27:24])
        end
        bus(1'b0, 6'h08, 32'h0, 4'h0);
        `CHK("nan event", 1'b1, rd[1])
        $display("test cc done");
    endtask
    task automatic t_preds;
        bus(1'b1, 6'h00, 32'h00008000, 4'hF);
        for (int c = 0; c < 8; c++) begin
            host.report(c[0], c[1], 1'b0, c[2], 1'b0);
            for (int p = 0; p < 64; p++) begin
                host.evaluate(p[5:0], dn, tv, tp);
                `CHK("done", 1'b1, dn)
                `CHK("outcome", exp_true(p[5:0], c[2], c[1] & ~c[2], c[0]), tv)
                `CHK("trap", ~p[5] & p[4] & c[2], tp)
            end
        end
        bus(1'b0, 6'h10, 32'h0, 4'h0);
        `CHK("last eval", 10'h23F, rd[9:0])
        $display("test predicates done");
    endtask
    task automatic t_irq;
        bus(1'b0, 6'h04, 32'h0, 4'h0);
        `CHK("flag sticky", 1'b1, rd[15])
        bus(1'b0, 6'h08, 32'h0, 4'h0);
        `CHK("int status", 3'h7, rd[2:0])
        bus(1'b1, 6'h0C, 32'h1, 4'hF);
        @(negedge clock);
        `CHK("irq on", 1'b1, irq)
        bus(1'b1, 6'h0C, 32'h0, 4'hF);
        @(negedge clock);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, 6'h0C, 32'h1, 4'hF);
        bus(1'b1, 6'h08, 32'h7, 4'hF);
        @(negedge clock);
        `CHK("irq cleared", 1'b0, irq)
        bus(1'b1, 6'h04, 32'h00008000, 4'h2);
        bus(1'b0, 6'h04, 32'h0, 4'h0);
        `CHK("flag cleared", 1'b0, rd[15])
        $display("test irq done");
    endtask
    task automatic t_notrap;
        bus(1'b1, 6'h00, 32'h0, 4'hF);
        host.report(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        host.evaluate(6'h01, dn, tv, tp);
        bus(1'b0, 6'h04, 32'h0, 4'h0);
        `CHK("equal quiet", 1'b0, rd[15])
        host.evaluate(6'h12, dn, tv, tp);
        `CHK("trap off", 1'b0, tp)
        bus(1'b0, 6'h04, 32'h0, 4'h0);
        `CHK("flag set", 1'b1, rd[15])
        $display("test trap disabled done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        $display("watchdog expired");
        report_and_stop;
    end
    initial begin
        clock = 1'b0;
        rst_b = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        failures = 0;
        check_count = 0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        t_regs;
        t_cc;
        t_preds;
        t_irq;
        t_notrap;
        report_and_stop;
    end
endmodule
bind fpcpe_top fpcpe_properties u_props (.clock(clock), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .res_valid(res_valid),
    .res_neg(res_neg), .res_zero(res_zero), .res_inf(res_inf), .res_nan(res_nan),
    .res_unordered(res_unordered), .eval_valid(eval_valid), .eval_pred(eval_pred),
    .eval_done(eval_done), .eval_true(eval_true), .eval_trap(eval_trap), .irq(irq));
`default_nettype wire
